// ===== include/faat_map.svh
// Constants for the flash program and erase host sequencer.
// How it works
// RL1: Device programs one byte, verifying internally.
// RL2: Poll bit shows complement, then true data.
// RL3: Chip erase clears all, verifying internally.
// RL4: Poll bit reads zero during erase, one after.
// RL5: Sector erase clears only the addressed sector.
// RL6: Chip erase timeout allows 64 seconds.
// RL7: Sector erase timeout allows 10.4 seconds.
// RL8: Byte program timeout allows 210 microseconds.
// RL9: Sector address window of 80 microseconds kept.
// RL10: Reset during algorithm: ready within 20 microseconds.
// RL11: Reset when idle: ready within 500 nanoseconds.
// RL12: Reset held low at least 10 microseconds.
// RL13: Wait 50 ns after ready before write.
// RL14: Elevated reset 4 microseconds before writes.
// RL15: Protect write pulse at least 10 microseconds.
// RL16: Unprotect write pulse at least 12 milliseconds.
// RL17: Output enable level set 4 microseconds before write.
// RL18: Device powers up in read mode.
// RL19: Protection query returns one on lowest bit.
// RL20: Ready/busy shows busy throughout any algorithm.
`ifndef FAAT_MAP_SVH
`define FAAT_MAP_SVH
`define FAAT_ADDR_W 20
`define FAAT_DATA_W 8
`define FAAT_POLL_BIT 7
`define FAAT_ERASED_POLL 1'h1
`define FAAT_CLK_NS 50
`define FAAT_SYNC_CYC 2
`define FAAT_CYC(ns) ((((ns) + `FAAT_CLK_NS - 1) / `FAAT_CLK_NS) < 1 ? 1 : (((ns) + `FAAT_CLK_NS - 1) / `FAAT_CLK_NS))
`define FAAT_T_ACC_NS 120
`define FAAT_T_WE_LOW_NS 50
`define FAAT_T_WE_HIGH_NS 20
`define FAAT_T_RB2_NS 50
`define FAAT_T_VIDR_NS 500
`define FAAT_T_RP1_US 10
`define FAAT_T_READY1_US 20
`define FAAT_T_BAL_US 80
`define FAAT_T_OESP_US 4
`define FAAT_T_WPP1_US 10
`define FAAT_T_RSP_US 4
`define FAAT_T_PROG_MAX_US 210
`define FAAT_T_WPP2_MS 12
`define FAAT_T_SECT_MAX_S 10.4
`define FAAT_T_CHIP_MAX_S 64
`define FAAT_ACC_CYC (`FAAT_CYC(`FAAT_T_ACC_NS) + `FAAT_SYNC_CYC)
`define FAAT_WE_LOW_CYC `FAAT_CYC(`FAAT_T_WE_LOW_NS)
`define FAAT_WE_HIGH_CYC `FAAT_CYC(`FAAT_T_WE_HIGH_NS)
`define FAAT_RB2_CYC `FAAT_CYC(`FAAT_T_RB2_NS)
`define FAAT_VIDR_CYC `FAAT_CYC(`FAAT_T_VIDR_NS)
`define FAAT_RP1_CYC `FAAT_CYC(`FAAT_T_RP1_US * 1000)
`define FAAT_READY1_CYC `FAAT_CYC(`FAAT_T_READY1_US * 1000)
`define FAAT_BAL_CYC `FAAT_CYC(`FAAT_T_BAL_US * 1000)
`define FAAT_OESP_CYC `FAAT_CYC(`FAAT_T_OESP_US * 1000)
`define FAAT_WPP1_CYC `FAAT_CYC(`FAAT_T_WPP1_US * 1000)
`define FAAT_RSP_CYC `FAAT_CYC(`FAAT_T_RSP_US * 1000)
`endif

// ===== include/faat_pkg.sv
// Types shared by the flash host sequencer and its timer.
`include "faat_map.svh"
package faat_pkg;
  typedef enum logic [3:0] {
    FAAT_OP_NOP, FAAT_OP_READ, FAAT_OP_WRITE, FAAT_OP_POLL_PROG, FAAT_OP_POLL_CHIP,
    FAAT_OP_POLL_SECT, FAAT_OP_RESET, FAAT_OP_PROTECT, FAAT_OP_UNPROTECT,
    FAAT_OP_TEMP_ON, FAAT_OP_TEMP_OFF
  } faat_op_e;
  typedef enum logic [3:0] {
    FAAT_ST_IDLE, FAAT_ST_WR_GATE, FAAT_ST_WR_LOW, FAAT_ST_WR_HIGH, FAAT_ST_RD_WAIT,
    FAAT_ST_POLL_GAP, FAAT_ST_BAL_WAIT, FAAT_ST_RST_LOW, FAAT_ST_WAIT_END,
    FAAT_ST_HV_SETUP, FAAT_ST_HV_PULSE, FAAT_ST_HV_END
  } faat_state_e;
  typedef struct packed {
    logic                        valid;
    faat_op_e                    op;
    logic [`FAAT_ADDR_W-1:0]     addr;
    logic [`FAAT_DATA_W-1:0]     data;
  } faat_req_s;
  typedef struct packed {
    logic [`FAAT_ADDR_W-1:0]     addr;
    logic [`FAAT_DATA_W-1:0]     dq;
    logic                        dq_oe;
    logic                        ce_n;
    logic                        oe_n;
    logic                        we_n;
    logic                        reset_n;
    logic                        hv_a9;
    logic                        hv_oe;
    logic                        hv_reset;
  } faat_pin_s;
  typedef struct packed {
    logic                        done;
    logic                        timeout;
    logic [`FAAT_DATA_W-1:0]     rdata;
  } faat_resp_s;
  typedef struct packed {
    faat_state_e                 st;
    faat_op_e                    op;
    faat_pin_s                   pins;
    faat_resp_s                  resp;
    logic                        ready;
    logic                        expect_bit;
    logic                        rb_s1;
    logic                        rb_s2;
    logic [1:0]                  rb_cnt;
    logic [`FAAT_DATA_W-1:0]     dq_s1;
    logic [`FAAT_DATA_W-1:0]     dq_s2;
  } faat_regs_s;
  typedef struct packed {
    logic [31:0]                 count;
  } faat_timer_s;
endpackage : faat_pkg

// ===== hdl/faat_timer.sv
// Down counter that reports when a loaded delay has run out.
`timescale 1ns/100ps
module faat_timer (
  // Clock, reset and clock enable
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // Load and status
  input  wire logic        load_i,
  input  wire logic [31:0] value_i,
  output logic             zero_o
);
  faat_pkg::faat_timer_s t_reg;
  faat_pkg::faat_timer_s t_next;

  always_comb begin
    t_next = t_reg;
    if (load_i) begin
      t_next.count = value_i;
    end else if (t_reg.count != 32'h0000_0000) begin
      t_next.count = t_reg.count - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      t_reg <= '0;
    end else if (ce_i) begin
      t_reg <= t_next;
    end
  end

  assign zero_o = (t_reg.count == 32'h0000_0000);
endmodule : faat_timer

// ===== hdl/faat_host.sv
// Host sequencer that drives a parallel flash through its pins.
`timescale 1ns/100ps
`include "faat_map.svh"
module faat_host #(
  parameter int unsigned TO_PROG_CYC = int'(`FAAT_T_PROG_MAX_US * 1.0e3 / `FAAT_CLK_NS),
  parameter int unsigned TO_SECT_CYC = int'(`FAAT_T_SECT_MAX_S * 1.0e9 / `FAAT_CLK_NS),
  parameter int unsigned TO_CHIP_CYC = int'(`FAAT_T_CHIP_MAX_S * 1.0e9 / `FAAT_CLK_NS),
  parameter int unsigned WPP2_CYC    = int'(`FAAT_T_WPP2_MS * 1.0e6 / `FAAT_CLK_NS)
) (
  // Clock, reset and clock enable
  input  wire logic                      clock_i,
  input  wire logic                      rstn_i,
  input  wire logic                      ce_i,
  // User request and answer
  input  wire faat_pkg::faat_req_s       req_i,
  output logic                           req_ready_o,
  output faat_pkg::faat_resp_s           resp_o,
  // Flash pins
  output faat_pkg::faat_pin_s            pins_o,
  input  wire logic [`FAAT_DATA_W-1:0]   dq_i,
  input  wire logic                      ready_busy_n_i
);
  localparam int RP1_C  = `FAAT_RP1_CYC;
  localparam int RB2_C  = `FAAT_RB2_CYC;
  localparam int RSP_C  = `FAAT_RSP_CYC;
  localparam int WPP1_C = `FAAT_WPP1_CYC;
  localparam int OESP_C = `FAAT_OESP_CYC;

  faat_pkg::faat_regs_s r_reg;
  faat_pkg::faat_regs_s r_next;
  logic                 dly_load;
  logic [31:0]          dly_val;
  logic                 dly_zero;
  logic                 lim_load;
  logic [31:0]          lim_val;
  logic                 lim_zero;
  logic                 is_poll;

  faat_timer u_delay (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .load_i  (dly_load),
    .value_i (dly_val),
    .zero_o  (dly_zero)
  );

  faat_timer u_limit (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .load_i  (lim_load),
    .value_i (lim_val),
    .zero_o  (lim_zero)
  );

  assign is_poll = (r_reg.op == faat_pkg::FAAT_OP_POLL_PROG) || (r_reg.op == faat_pkg::FAAT_OP_POLL_CHIP) ||
                   (r_reg.op == faat_pkg::FAAT_OP_POLL_SECT);

  always_comb begin
    r_next = r_reg;
    dly_load = 1'h0;
    dly_val = 32'h0000_0000;
    lim_load = 1'h0;
    lim_val = 32'h0000_0000;
    r_next.resp.done = 1'h0;
    r_next.rb_s1 = ready_busy_n_i;
    r_next.rb_s2 = r_reg.rb_s1;
    r_next.dq_s1 = dq_i;
    r_next.dq_s2 = r_reg.dq_s1;
    if (!r_reg.rb_s2) begin
      r_next.rb_cnt = 2'h0;
    end else if (r_reg.rb_cnt != 2'h3) begin
      r_next.rb_cnt = r_reg.rb_cnt + 2'h1;
    end
    case (r_reg.st)
      faat_pkg::FAAT_ST_IDLE: begin
        if (r_reg.ready && req_i.valid) begin
          r_next.ready = 1'h0;
          r_next.op = req_i.op;
          r_next.resp.timeout = 1'h0;
          r_next.pins.addr = req_i.addr;
          r_next.pins.dq = req_i.data;
          r_next.expect_bit = `FAAT_ERASED_POLL;
          case (req_i.op)
            faat_pkg::FAAT_OP_READ: begin
              r_next.pins.ce_n = 1'h0;
              r_next.pins.oe_n = 1'h0;
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_ACC_CYC);
              r_next.st = faat_pkg::FAAT_ST_RD_WAIT;
            end
            faat_pkg::FAAT_OP_WRITE: begin
              r_next.st = faat_pkg::FAAT_ST_WR_GATE;
            end
            faat_pkg::FAAT_OP_POLL_PROG: begin
              r_next.expect_bit = req_i.data[`FAAT_POLL_BIT]; // [RL2]
              lim_load = 1'h1;
              lim_val = 32'(TO_PROG_CYC); // [RL8]
              r_next.st = faat_pkg::FAAT_ST_POLL_GAP;
            end
            faat_pkg::FAAT_OP_POLL_CHIP: begin
              lim_load = 1'h1;
              lim_val = 32'(TO_CHIP_CYC); // [RL6] [RL4]
              r_next.st = faat_pkg::FAAT_ST_POLL_GAP;
            end
            faat_pkg::FAAT_OP_POLL_SECT: begin
              lim_load = 1'h1;
              lim_val = 32'(TO_SECT_CYC); // [RL7]
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_BAL_CYC); // [RL9]
              r_next.st = faat_pkg::FAAT_ST_BAL_WAIT;
            end
            faat_pkg::FAAT_OP_RESET: begin
              r_next.pins.reset_n = 1'h0;
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_RP1_CYC); // [RL12]
              r_next.st = faat_pkg::FAAT_ST_RST_LOW;
            end
            faat_pkg::FAAT_OP_PROTECT, faat_pkg::FAAT_OP_UNPROTECT: begin
              r_next.pins.hv_a9 = 1'h1;
              r_next.pins.hv_oe = 1'h1;
              r_next.pins.ce_n = 1'h0;
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_OESP_CYC); // [RL17]
              r_next.st = faat_pkg::FAAT_ST_HV_SETUP;
            end
            faat_pkg::FAAT_OP_TEMP_ON: begin
              r_next.pins.hv_reset = 1'h1;
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_RSP_CYC); // [RL14]
              r_next.st = faat_pkg::FAAT_ST_WAIT_END;
            end
            faat_pkg::FAAT_OP_TEMP_OFF: begin
              r_next.pins.hv_reset = 1'h0;
              dly_load = 1'h1;
              dly_val = 32'(`FAAT_VIDR_CYC);
              r_next.st = faat_pkg::FAAT_ST_WAIT_END;
            end
            default: begin
              r_next.ready = 1'h1;
              r_next.resp.done = 1'h1;
            end
          endcase
        end
      end
      faat_pkg::FAAT_ST_WR_GATE: begin
        if (r_reg.rb_s2 && (r_reg.rb_cnt >= 2'(`FAAT_RB2_CYC))) begin // [RL13]
          r_next.pins.ce_n = 1'h0;
          r_next.pins.we_n = 1'h0;
          r_next.pins.dq_oe = 1'h1;
          dly_load = 1'h1;
          dly_val = 32'(`FAAT_WE_LOW_CYC);
          r_next.st = faat_pkg::FAAT_ST_WR_LOW;
        end
      end
      faat_pkg::FAAT_ST_WR_LOW: begin
        if (dly_zero) begin
          r_next.pins.we_n = 1'h1;
          r_next.pins.ce_n = 1'h1;
          dly_load = 1'h1;
          dly_val = 32'(`FAAT_WE_HIGH_CYC);
          r_next.st = faat_pkg::FAAT_ST_WR_HIGH;
        end
      end
      faat_pkg::FAAT_ST_WR_HIGH: begin
        if (dly_zero) begin
          r_next.pins.dq_oe = 1'h0;
          r_next.ready = 1'h1;
          r_next.resp.done = 1'h1;
          r_next.st = faat_pkg::FAAT_ST_IDLE;
        end
      end
      faat_pkg::FAAT_ST_BAL_WAIT: begin
        if (dly_zero) begin
          r_next.st = faat_pkg::FAAT_ST_POLL_GAP; // [RL9]
        end
      end
      faat_pkg::FAAT_ST_POLL_GAP: begin
        r_next.pins.ce_n = 1'h0;
        r_next.pins.oe_n = 1'h0;
        dly_load = 1'h1;
        dly_val = 32'(`FAAT_ACC_CYC);
        r_next.st = faat_pkg::FAAT_ST_RD_WAIT;
      end
      faat_pkg::FAAT_ST_RD_WAIT: begin
        if (dly_zero) begin
          r_next.resp.rdata = r_reg.dq_s2;
          r_next.pins.ce_n = 1'h1;
          r_next.pins.oe_n = 1'h1;
          if (is_poll && (r_reg.dq_s2[`FAAT_POLL_BIT] != r_reg.expect_bit)) begin // [RL2] [RL4]
            if (lim_zero) begin
              r_next.resp.timeout = 1'h1; // [RL6] [RL7] [RL8]
              r_next.ready = 1'h1;
              r_next.resp.done = 1'h1;
              r_next.st = faat_pkg::FAAT_ST_IDLE;
            end else begin
              r_next.st = faat_pkg::FAAT_ST_POLL_GAP;
            end
          end else begin
            r_next.ready = 1'h1;
            r_next.resp.done = 1'h1;
            r_next.st = faat_pkg::FAAT_ST_IDLE;
          end
        end
      end
      faat_pkg::FAAT_ST_RST_LOW: begin
        if (dly_zero) begin
          r_next.pins.reset_n = 1'h1;
          dly_load = 1'h1;
          dly_val = 32'(`FAAT_READY1_CYC); // [RL10]
          r_next.st = faat_pkg::FAAT_ST_WAIT_END;
        end
      end
      faat_pkg::FAAT_ST_HV_SETUP: begin
        if (dly_zero) begin
          r_next.pins.we_n = 1'h0;
          dly_load = 1'h1;
          dly_val = (r_reg.op == faat_pkg::FAAT_OP_UNPROTECT) ? 32'(WPP2_CYC) : 32'(`FAAT_WPP1_CYC); // [RL15] [RL16]
          r_next.st = faat_pkg::FAAT_ST_HV_PULSE;
        end
      end
      faat_pkg::FAAT_ST_HV_PULSE: begin
        if (dly_zero) begin
          r_next.pins.we_n = 1'h1;
          dly_load = 1'h1;
          dly_val = 32'(`FAAT_VIDR_CYC);
          r_next.st = faat_pkg::FAAT_ST_HV_END;
        end
      end
      faat_pkg::FAAT_ST_HV_END: begin
        if (dly_zero) begin
          r_next.pins.hv_a9 = 1'h0;
          r_next.pins.hv_oe = 1'h0;
          r_next.pins.ce_n = 1'h1;
          r_next.ready = 1'h1;
          r_next.resp.done = 1'h1;
          r_next.st = faat_pkg::FAAT_ST_IDLE;
        end
      end
      faat_pkg::FAAT_ST_WAIT_END: begin
        if (dly_zero) begin
          r_next.ready = 1'h1;
          r_next.resp.done = 1'h1;
          r_next.st = faat_pkg::FAAT_ST_IDLE;
        end
      end
      default: begin
        r_next.st = faat_pkg::FAAT_ST_IDLE;
        r_next.ready = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg <= '{st: faat_pkg::FAAT_ST_IDLE, op: faat_pkg::FAAT_OP_NOP,
                 pins: '{addr: '0, dq: '0, dq_oe: 1'h0, ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1,
                         reset_n: 1'h1, hv_a9: 1'h0, hv_oe: 1'h0, hv_reset: 1'h0},
                 resp: '0, ready: 1'h1, expect_bit: 1'h0, rb_s1: 1'h0, rb_s2: 1'h0,
                 rb_cnt: 2'h0, dq_s1: '0, dq_s2: '0};
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign pins_o = r_reg.pins;
  assign resp_o = r_reg.resp;
  assign req_ready_o = r_reg.ready;

  // Pulse and level length counters watched by the checks below.
  logic [31:0] rst_low_cnt;
  logic [31:0] we_low_cnt;
  logic [31:0] hv_oe_cnt;
  logic [31:0] hv_rst_cnt;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_low_cnt <= 32'h0000_0000;
      we_low_cnt <= 32'h0000_0000;
      hv_oe_cnt <= 32'h0000_0000;
      hv_rst_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      rst_low_cnt <= r_reg.pins.reset_n ? 32'h0000_0000 : rst_low_cnt + 32'h0000_0001;
      we_low_cnt <= r_reg.pins.we_n ? 32'h0000_0000 : we_low_cnt + 32'h0000_0001;
      hv_oe_cnt <= r_reg.pins.hv_oe ? hv_oe_cnt + 32'h0000_0001 : 32'h0000_0000;
      hv_rst_cnt <= r_reg.pins.hv_reset ? hv_rst_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_rst_release;
    $rose(r_reg.pins.reset_n);
  endsequence

  property p_rst_hold;
    s_rst_release |-> $past(rst_low_cnt) >= RP1_C;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Reset pulse too short."); // [RL12]

  property p_rst_recover;
    s_rst_release |-> !r_reg.resp.done [*8];
  endproperty
  a_rst_recover: assert property (p_rst_recover) else $error("Reset recovery wait cut short."); // [RL10]

  property p_rb_before_we;
    ($fell(r_reg.pins.we_n) && !r_reg.pins.hv_a9) |-> ($past(r_reg.rb_s2) && $past(r_reg.rb_cnt) >= RB2_C);
  endproperty
  a_rb_before_we: assert property (p_rb_before_we) else $error("Write strobe too soon after ready."); // [RL13]

  property p_temp_setup;
    ($fell(r_reg.pins.we_n) && r_reg.pins.hv_reset) |-> $past(hv_rst_cnt) >= RSP_C;
  endproperty
  a_temp_setup: assert property (p_temp_setup) else $error("Write too soon after elevated reset."); // [RL14]

  property p_wpp1;
    ($rose(r_reg.pins.we_n) && r_reg.pins.hv_a9 && r_reg.op == faat_pkg::FAAT_OP_PROTECT)
      |-> $past(we_low_cnt) >= WPP1_C;
  endproperty
  a_wpp1: assert property (p_wpp1) else $error("Protect pulse too short."); // [RL15]

  property p_wpp2;
    ($rose(r_reg.pins.we_n) && r_reg.pins.hv_a9 && r_reg.op == faat_pkg::FAAT_OP_UNPROTECT)
      |-> $past(we_low_cnt) >= WPP2_CYC;
  endproperty
  a_wpp2: assert property (p_wpp2) else $error("Unprotect pulse too short."); // [RL16]

  property p_oesp;
    ($fell(r_reg.pins.we_n) && r_reg.pins.hv_oe) |-> $past(hv_oe_cnt) >= OESP_C;
  endproperty
  a_oesp: assert property (p_oesp) else $error("Output enable level set too late."); // [RL17]

  property p_bal;
    (r_reg.st == faat_pkg::FAAT_ST_BAL_WAIT && $past(r_reg.st) != faat_pkg::FAAT_ST_BAL_WAIT)
      |-> r_reg.pins.oe_n [*8];
  endproperty
  a_bal: assert property (p_bal) else $error("Status read inside sector load window."); // [RL9]
endmodule : faat_host

// ===== test/faat_flash_model.sv
// Behavioural flash device that answers the host sequencer.
`timescale 1ns/100ps
module faat_flash_model #(
  parameter int PROG_NS  = 1000,
  parameter int SLOW_NS  = 20000,
  parameter int ERASE_NS = 2000,
  parameter int WPP2_NS  = 15000
) (
  // Pins from the host and the slow program select
  input  wire faat_pkg::faat_pin_s pins_i,
  input  wire logic                slow_i,
  // Answer to the host and the violation count
  output logic [7:0]               dq_o,
  output logic                     ready_busy_n_o,
  output int                       viol_o
);
  logic [7:0]  mem [int];
  logic [7:0]  prog_val = 8'h00, last_q = 8'h00;
  logic [19:0] op_addr = 20'h0_0000;
  logic        erasing = 1'b0, id_mode = 1'b0, prot = 1'b0, arm = 1'b0, tgl = 1'b0, win = 1'b0, rst_busy = 1'b0;
  realtime     t_rdy = -1000.0, t_hv = 0.0, t_hvr = 0.0, t_we = 0.0, t_rst = -1.0e6;

  initial begin
    ready_busy_n_o = 1'b1;
    viol_o = 0;
  end

  // Busy for a while unless the reset pin cuts the algorithm short.
  task automatic run(input int d);
    ready_busy_n_o = 1'b0;
    fork
      #(d);
      @(negedge pins_i.reset_n) rst_busy = 1'b1;
    join_any
    disable fork;
    ready_busy_n_o = 1'b1;
    t_rdy = $realtime;
  endtask : run

  always @(negedge pins_i.we_n) begin
    if (pins_i.hv_a9) begin
      t_we = $realtime;
      if (t_we - t_hv < 4000.0) viol_o++;
    end else if (!pins_i.ce_n) begin
      if (!ready_busy_n_o || $realtime - t_rdy < 50.0) viol_o++;
      if (pins_i.hv_reset && $realtime - t_hvr < 4000.0) viol_o++;
      if (arm) begin
        arm = 1'b0;
        erasing = 1'b0;
        prog_val = pins_i.dq;
        op_addr = pins_i.addr;
        run(slow_i ? SLOW_NS : PROG_NS);
        if (!rst_busy) mem[int'(op_addr)] = prog_val;
      end else case (pins_i.dq)
        8'hA0: arm = 1'b1;
        8'h90: id_mode = 1'b1;
        8'hF0: id_mode = 1'b0;
        8'h10: begin
          erasing = 1'b1;
          run(ERASE_NS);
          if (!rst_busy) mem.delete();
        end
        8'h30: begin
          erasing = 1'b1;
          op_addr = pins_i.addr;
          ready_busy_n_o = 1'b0;
          win = 1'b1;
          #80000;
          win = 1'b0;
          run(ERASE_NS);
          if (!rst_busy) foreach (mem[k]) if (k[19:16] == op_addr[19:16]) mem[k] = 8'hFF;
        end
        default: ;
      endcase
    end
  end

  always @(posedge pins_i.we_n) begin
    if (pins_i.hv_a9 && pins_i.hv_oe && pins_i.addr[6]) begin
      if ($realtime - t_we < WPP2_NS) viol_o++;
      prot = 1'b0;
    end else if (pins_i.hv_a9 && pins_i.hv_oe) begin
      if ($realtime - t_we < 10000.0) viol_o++;
      prot = 1'b1;
    end
  end

  always @(negedge pins_i.oe_n) begin
    tgl = ~tgl;
    if (win) viol_o++;
  end

  always @(posedge pins_i.hv_oe) t_hv = $realtime;
  always @(posedge pins_i.hv_reset) t_hvr = $realtime;

  always @(negedge pins_i.reset_n) begin
    t_rst = $realtime;
    arm = 1'b0;
    id_mode = 1'b0;
  end

  always @(posedge pins_i.reset_n) begin
    if ($realtime > 1.0 && $realtime - t_rst < (rst_busy ? 10000.0 : 500.0)) viol_o++;
    rst_busy = 1'b0;
  end

  // Drives the bus only while selected; released lines show the inverse of the last value.
  always @(pins_i or ready_busy_n_o or tgl) begin
    if (!pins_i.ce_n && !pins_i.oe_n && !pins_i.hv_a9) begin
      if (!ready_busy_n_o) dq_o = erasing ? {1'b0, tgl, 6'h00} : {~prog_val[7], tgl, prog_val[5:0]};
      else if (id_mode) dq_o = {7'h00, pins_i.addr[1] & prot};
      else dq_o = mem.exists(int'(pins_i.addr)) ? mem[int'(pins_i.addr)] : 8'hFF;
      last_q = dq_o;
    end else begin
      dq_o = ~last_q;
    end
  end
endmodule : faat_flash_model

// ===== test/flash_auto_algorithm_timing_tb_top.sv
// Self-checking bench for the flash host sequencer against a device model.
`timescale 1ns/100ps
module flash_auto_algorithm_timing_tb_top;
  typedef struct packed {
    faat_pkg::faat_op_e op;
    logic [19:0]        addr;
    logic [7:0]         data;
    logic               slow;
    logic [9:0]         cyc;
    logic               chk;
    logic [7:0]         exp_rd;
    logic               exp_to;
  } faat_row_s;
  localparam faat_pkg::faat_op_e WR = faat_pkg::FAAT_OP_WRITE;
  localparam faat_pkg::faat_op_e RD = faat_pkg::FAAT_OP_READ;
  localparam faat_pkg::faat_op_e PP = faat_pkg::FAAT_OP_POLL_PROG;
  localparam faat_pkg::faat_pin_s IDLE = '{20'h0_0000, 8'h00, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  localparam int NROW = 33;
  localparam faat_row_s ROWS [NROW] = '{
    '{faat_pkg::FAAT_OP_NOP, 20'h0_0000, 8'h00, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{RD, 20'h0_0010, 8'h00, 1'h0, 10'h006, 1'h1, 8'hFF, 1'h0},
    '{WR, 20'h0_0555, 8'hA0, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0010, 8'h5A, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0555, 8'hF0, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{PP, 20'h0_0010, 8'h5A, 1'h0, 10'h000, 1'h1, 8'h5A, 1'h0},
    '{WR, 20'h0_0555, 8'hA0, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h2_0000, 8'h33, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{PP, 20'h2_0000, 8'h33, 1'h0, 10'h000, 1'h1, 8'h33, 1'h0},
    '{RD, 20'h0_0010, 8'h00, 1'h0, 10'h006, 1'h1, 8'h5A, 1'h0},
    '{WR, 20'h0_0000, 8'h30, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{faat_pkg::FAAT_OP_POLL_SECT, 20'h0_0000, 8'h00, 1'h0, 10'h000, 1'h1, 8'hFF, 1'h0},
    '{RD, 20'h0_0010, 8'h00, 1'h0, 10'h006, 1'h1, 8'hFF, 1'h0},
    '{RD, 20'h2_0000, 8'h00, 1'h0, 10'h006, 1'h1, 8'h33, 1'h0},
    '{WR, 20'h0_0555, 8'h10, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{faat_pkg::FAAT_OP_POLL_CHIP, 20'h2_0000, 8'h00, 1'h0, 10'h000, 1'h1, 8'hFF, 1'h0},
    '{RD, 20'h2_0000, 8'h00, 1'h0, 10'h006, 1'h1, 8'hFF, 1'h0},
    '{faat_pkg::FAAT_OP_PROTECT, 20'h0_0000, 8'h00, 1'h0, 10'h125, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0555, 8'h90, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{RD, 20'h0_0002, 8'h00, 1'h0, 10'h006, 1'h1, 8'h01, 1'h0},
    '{faat_pkg::FAAT_OP_UNPROTECT, 20'h0_0040, 8'h00, 1'h0, 10'h189, 1'h0, 8'h00, 1'h0},
    '{RD, 20'h0_0002, 8'h00, 1'h0, 10'h006, 1'h1, 8'h00, 1'h0},
    '{WR, 20'h0_0555, 8'hF0, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{faat_pkg::FAAT_OP_TEMP_ON, 20'h0_0000, 8'h00, 1'h0, 10'h051, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0555, 8'hA0, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0100, 8'hC3, 1'h0, 10'h000, 1'h0, 8'h00, 1'h0},
    '{PP, 20'h0_0100, 8'hC3, 1'h0, 10'h000, 1'h1, 8'hC3, 1'h0},
    '{faat_pkg::FAAT_OP_TEMP_OFF, 20'h0_0000, 8'h00, 1'h0, 10'h00B, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0555, 8'hA0, 1'h1, 10'h000, 1'h0, 8'h00, 1'h0},
    '{WR, 20'h0_0200, 8'h11, 1'h1, 10'h000, 1'h0, 8'h00, 1'h0},
    '{PP, 20'h0_0200, 8'h11, 1'h1, 10'h000, 1'h0, 8'h00, 1'h1},
    '{faat_pkg::FAAT_OP_RESET, 20'h0_0000, 8'h00, 1'h0, 10'h25A, 1'h0, 8'h00, 1'h0},
    '{RD, 20'h0_0200, 8'h00, 1'h0, 10'h006, 1'h1, 8'hFF, 1'h0}
  };

  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ce = 1'b1;
  logic                 slow = 1'b0;
  faat_pkg::faat_req_s  req = '0;
  logic                 req_ready;
  faat_pkg::faat_resp_s resp;
  faat_pkg::faat_pin_s  pins;
  logic [7:0]           flash_dq;
  logic [7:0]           bus;
  logic                 rb_n;
  int                   viol;
  int                   n_fail = 0;
  int                   total_checks = 0;

  assign bus = pins.dq_oe ? pins.dq : flash_dq;
  always #25 clock = ~clock;

  faat_host #(.TO_PROG_CYC(50), .TO_SECT_CYC(2000), .TO_CHIP_CYC(300), .WPP2_CYC(300)) u_faat_host (
    .clock_i(clock), .rstn_i(rstn), .ce_i(ce), .req_i(req), .req_ready_o(req_ready),
    .resp_o(resp), .pins_o(pins), .dq_i(bus), .ready_busy_n_i(rb_n));

  faat_flash_model #(.WPP2_NS(15000)) u_faat_flash_model (
    .pins_i(pins), .slow_i(slow), .dq_o(flash_dq), .ready_busy_n_o(rb_n), .viol_o(viol));

  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic chk_idle();
    check("pins", pins, IDLE);
    check("req_ready", req_ready, 1'h1);
    check("resp", resp, '0);
  endtask : chk_idle

  // Issues one request and waits for its done pulse, counting cycles from the taking edge.
  task automatic do_op(input faat_row_s r, output int n);
    @(posedge clock);
    slow <= r.slow;
    req <= '{1'h1, r.op, r.addr, r.data};
    @(posedge clock);
    req.valid <= 1'h0;
    n = 0;
    #1;
    while (resp.done !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 5000) begin
      check("done", 1'h0, 1'h1);
      tally_and_finish();
    end
  endtask : do_op

  initial begin
    int n;
    repeat (5) @(posedge clock);
    chk_idle();
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    #1;
    chk_idle();
    for (int i = 0; i < NROW; i++) begin
      do_op(ROWS[i], n);
      if (ROWS[i].cyc != 10'h000 || ROWS[i].op == faat_pkg::FAAT_OP_NOP) begin
        check("cycles", n, ROWS[i].cyc);
      end
      if (ROWS[i].chk) check("rdata", resp.rdata, ROWS[i].exp_rd);
      check("timeout", resp.timeout, ROWS[i].exp_to);
    end
    // A second reset in the middle of a read must park every pin at once.
    @(posedge clock);
    req <= '{1'h1, RD, 20'h0_0010, 8'h00};
    repeat (3) @(posedge clock);
    req.valid <= 1'h0;
    rstn <= 1'h0;
    #1;
    chk_idle();
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    #1;
    chk_idle();
    // Clock enable low freezes the sequencer, so a waiting read is not taken.
    @(posedge clock);
    ce <= 1'b0;
    req <= '{1'h1, RD, 20'h0_0010, 8'h00};
    repeat (4) @(posedge clock);
    #1;
    chk_idle();
    @(posedge clock);
    ce <= 1'b1;
    @(posedge clock);
    req.valid <= 1'h0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (resp.done !== 1'b1 && n < 20);
    check("cycles", n, 6);
    check("rdata", resp.rdata, 8'hFF);
    check("host timing", viol, 0);
    tally_and_finish();
  end
endmodule : flash_auto_algorithm_timing_tb_top
